// file: spp_shared_pin_port.sv
// shared pin parallel port with axi4-lite register slave
// Notes on behaviour
// - mux pair picks pin data and enable source
// - port output never loops into peripheral input
// - driving peripheral enables port output driver
// - level reads show real pins under peripheral
// - idle enabled peripheral leaves pin to port
// - direction one is input, zero output
// - every reset makes all pins inputs
// - latch register reads and writes the latch
// - level reads pins, level writes the latch
// - unimplemented bits disabled, read as zero
// - input-only peripheral pins are port owned
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "spp_map.svh"
module spp_shared_pin_port #(
  parameter int PIN_COUNT = 16,
  parameter logic [31:0] IMPL_MASK = 32'h0000FFFF,
  parameter logic [31:0] INPUT_ONLY_MASK = 32'h00000000,
  parameter int ADDR_W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PIN_COUNT-1:0] pinIn,
  output logic [PIN_COUNT-1:0] pinOut,
  output logic [PIN_COUNT-1:0] pinOeN,
  input wire logic [PIN_COUNT-1:0] periphEnable,
  input wire logic [PIN_COUNT-1:0] periphDrive,
  input wire logic [PIN_COUNT-1:0] periphOut,
  output logic [PIN_COUNT-1:0] periphIn
);

  // refuse widths the 32-bit registers cannot hold
  if (PIN_COUNT < 1 || PIN_COUNT > 32 || ADDR_W < 4) begin : g_bad_params
    $error("spp_shared_pin_port: PIN_COUNT must be 1..32 and ADDR_W at least 4");
  end

  localparam logic [PIN_COUNT-1:0] IMPL = IMPL_MASK[PIN_COUNT-1:0];
  localparam logic [PIN_COUNT-1:0] IN_ONLY = INPUT_ONLY_MASK[PIN_COUNT-1:0];
  localparam logic [31:0] DIR_RST_W = `SPP_DIR_RESET;
  localparam logic [31:0] LAT_RST_W = `SPP_LATCH_RESET;
  localparam logic [PIN_COUNT-1:0] DIR_RST = DIR_RST_W[PIN_COUNT-1:0];
  localparam logic [PIN_COUNT-1:0] LAT_RST = LAT_RST_W[PIN_COUNT-1:0];

  // expand byte strobes into a bit mask for the low pin bits
  function automatic logic [PIN_COUNT-1:0] strbMask(input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return m[PIN_COUNT-1:0];
  endfunction

  // decode a byte address into a register select; high bits must be zero
  function automatic logic addrHit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] hi;
    hi = a >> 4;
    return (hi == '0) && (a[1:0] == 2'h0);
  endfunction

  function automatic spp_pkg::spp_reg_sel_t addrSel(input logic [ADDR_W-1:0] a);
    return spp_pkg::spp_reg_sel_t'(a[3:2]);
  endfunction

  // zero-extend a pin vector to the bus width
  function automatic logic [31:0] widen(input logic [PIN_COUNT-1:0] v);
    logic [31:0] w;
    w = '0;
    w[PIN_COUNT-1:0] = v;
    return w;
  endfunction

  logic [PIN_COUNT-1:0] pinDirection_reg;
  logic [PIN_COUNT-1:0] outputLatch_reg;
  logic [PIN_COUNT-1:0] pinSync1_reg;
  logic [PIN_COUNT-1:0] pinSync2_reg;
  logic [PIN_COUNT-1:0] periphOwn;
  logic [PIN_COUNT-1:0] portDriving;
  logic [PIN_COUNT-1:0] pinOut_reg;
  logic [PIN_COUNT-1:0] pinOeN_reg;
  logic [PIN_COUNT-1:0] periphIn_reg;
  logic [PIN_COUNT-1:0] drove1_reg, drove2_reg, drove3_reg;
  spp_pkg::spp_wr_state_t wrState_reg;
  spp_pkg::spp_wr_state_t wrState_next;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awReady_reg;
  logic wReady_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic arReady_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;
  logic awHs;
  logic wHs;
  logic doWrite;
  logic [ADDR_W-1:0] effAddr;
  logic [31:0] effData;
  logic [PIN_COUNT-1:0] effMask;

  // ownership: only an enabled peripheral that is actively driving takes the pin
  assign periphOwn = periphEnable & periphDrive & ~IN_ONLY & IMPL;
  // port drives only when it owns the pin and its direction bit says output
  assign portDriving = ~periphOwn & ~pinDirection_reg & IMPL;

  // two-flop synchroniser; the first stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinSync1_reg <= '0;
      pinSync2_reg <= '0;
    end else begin
      pinSync1_reg <= pinIn;
      pinSync2_reg <= pinSync1_reg & IMPL;
    end
  end

  // output mux pair for data and enable; oe is low while driving
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinOut_reg <= '0;
      pinOeN_reg <= '1;
    end else begin
      pinOut_reg <= ((periphOwn & periphOut) | (~periphOwn & outputLatch_reg)) & IMPL;
      pinOeN_reg <= ~(periphOwn | portDriving);
    end
  end

  // peripheral input sees the pin except where the port drives it or did so lately;
  // the enable flop and two sync stages lag, so three delayed copies of the drive mask also block a port bit just released
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periphIn_reg <= '0;
      drove1_reg <= '0;
      drove2_reg <= '0;
      drove3_reg <= '0;
    end else begin
      drove1_reg <= portDriving;
      drove2_reg <= drove1_reg;
      drove3_reg <= drove2_reg;
      periphIn_reg <= pinSync2_reg & ~(portDriving | drove1_reg | drove2_reg | drove3_reg);
    end
  end

  assign awHs = s_axi_awvalid && awReady_reg;
  assign wHs = s_axi_wvalid && wReady_reg;

  // write channel sequencer: address and data in either order, then response
  always_comb begin
    wrState_next = wrState_reg;
    case (wrState_reg)
      spp_pkg::SPP_WR_IDLE: begin
        if (awHs && wHs) begin
          wrState_next = spp_pkg::SPP_WR_RESP;
        end else if (awHs) begin
          wrState_next = spp_pkg::SPP_WR_ADDR;
        end else if (wHs) begin
          wrState_next = spp_pkg::SPP_WR_DATA;
        end
      end
      spp_pkg::SPP_WR_ADDR: begin
        if (wHs) begin
          wrState_next = spp_pkg::SPP_WR_RESP;
        end
      end
      spp_pkg::SPP_WR_DATA: begin
        if (awHs) begin
          wrState_next = spp_pkg::SPP_WR_RESP;
        end
      end
      spp_pkg::SPP_WR_RESP: begin
        if (s_axi_bready) begin
          wrState_next = spp_pkg::SPP_WR_IDLE;
        end
      end
      default: begin
        wrState_next = spp_pkg::SPP_WR_IDLE;
      end
    endcase
  end

  assign doWrite = (wrState_next == spp_pkg::SPP_WR_RESP) && (wrState_reg != spp_pkg::SPP_WR_RESP);
  // a channel taken in this very cycle wins over the held copy
  assign effAddr = awHs ? s_axi_awaddr : awAddr_reg;
  assign effData = wHs ? s_axi_wdata : wData_reg;
  assign effMask = strbMask(wHs ? s_axi_wstrb : wStrb_reg) & IMPL;

  // write channel state, held payload and readies
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrState_reg <= spp_pkg::SPP_WR_IDLE;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
    end else begin
      wrState_reg <= wrState_next;
      if (awHs) begin
        awAddr_reg <= s_axi_awaddr;
      end
      if (wHs) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      awReady_reg <= (wrState_next == spp_pkg::SPP_WR_IDLE) || (wrState_next == spp_pkg::SPP_WR_DATA);
      wReady_reg <= (wrState_next == spp_pkg::SPP_WR_IDLE) || (wrState_next == spp_pkg::SPP_WR_ADDR);
    end
  end

  // write response; unmapped addresses answer decode error and change nothing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bValid_reg <= 1'b0;
      bResp_reg <= `SPP_RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      bResp_reg <= addrHit(effAddr) ? `SPP_RESP_OKAY : `SPP_RESP_DECERR;
    end else if (bValid_reg && s_axi_bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // direction register, all inputs after reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinDirection_reg <= DIR_RST & IMPL;
    end else if (doWrite && addrHit(effAddr) && addrSel(effAddr) == spp_pkg::SPP_REG_DIR) begin
      pinDirection_reg <= (pinDirection_reg & ~effMask) | (effData[PIN_COUNT-1:0] & effMask);
    end
  end

  // latch takes writes from both the latch and the level offsets
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outputLatch_reg <= LAT_RST;
    end else if (doWrite && addrHit(effAddr) &&
                 (addrSel(effAddr) == spp_pkg::SPP_REG_LATCH ||
                  addrSel(effAddr) == spp_pkg::SPP_REG_LEVEL)) begin
      outputLatch_reg <= (outputLatch_reg & ~effMask) | (effData[PIN_COUNT-1:0] & effMask);
    end
  end

  // read channel: one read at a time, data registered one cycle after address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b0;
      rData_reg <= '0;
      rResp_reg <= `SPP_RESP_OKAY;
    end else if (s_axi_arvalid && arReady_reg) begin
      arReady_reg <= 1'b0;
      rValid_reg <= 1'b1;
      rResp_reg <= addrHit(s_axi_araddr) ? `SPP_RESP_OKAY : `SPP_RESP_DECERR;
      if (!addrHit(s_axi_araddr)) begin
        rData_reg <= '0;
      end else begin
        case (addrSel(s_axi_araddr))
          spp_pkg::SPP_REG_DIR: begin
            rData_reg <= widen(pinDirection_reg);
          end
          spp_pkg::SPP_REG_LATCH: begin
            rData_reg <= widen(outputLatch_reg);
          end
          spp_pkg::SPP_REG_LEVEL: begin
            rData_reg <= widen(pinSync2_reg);
          end
          spp_pkg::SPP_REG_OWNER: begin
            rData_reg <= widen(periphOwn);
          end
          default: begin
            rData_reg <= '0;
          end
        endcase
      end
    end else if (rValid_reg && s_axi_rready) begin
      rValid_reg <= 1'b0;
      arReady_reg <= 1'b1;
    end else if (!rValid_reg) begin
      arReady_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rdata = rData_reg;
  assign s_axi_rresp = rResp_reg;
  assign pinOut = pinOut_reg;
  assign pinOeN = pinOeN_reg;
  assign periphIn = periphIn_reg;

  // checks on the pin path and the register file
  a_mux_periph_data: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((pinOut_reg & $past(periphOwn)) == ($past(periphOut) & $past(periphOwn))))
    else $error("peripheral data not on owned pin");
  a_port_gets_idle: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((pinOut_reg & ~$past(periphOwn) & IMPL) == ($past(outputLatch_reg) & ~$past(periphOwn))))
    else $error("latch not on port owned pin");
  a_dir_sets_enable: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((pinOeN_reg & ~$past(periphOwn) & IMPL) == ($past(pinDirection_reg) & ~$past(periphOwn))))
    else $error("direction bit does not set driver");
  a_periph_drives: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((pinOeN_reg & $past(periphOwn)) == '0))
    else $error("driver off while peripheral drives");
  a_no_loop_through: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((periphIn_reg & ($past(portDriving) | $past(portDriving, 2) |
    $past(portDriving, 3) | $past(portDriving, 4))) == '0))
    else $error("port output looped into peripheral");
  a_sync_two_flops: assert property (@(posedge core_clk) disable iff (rst)
    !rst ##2 1'b1 |-> (pinSync2_reg == ($past(pinIn, 2) & IMPL)))
    else $error("synchroniser latency wrong");
  a_reset_inputs: assert property (@(posedge core_clk)
    rst |=> (pinDirection_reg == (DIR_RST & IMPL)) && (pinOeN_reg == '1))
    else $error("pins not inputs after reset");
  a_level_read: assert property (@(posedge core_clk) disable iff (rst)
    (s_axi_arvalid && arReady_reg && s_axi_araddr == `SPP_OFF_LEVEL) |=>
    (rValid_reg && rData_reg == widen($past(pinSync2_reg))))
    else $error("level read is not pin state");
  a_latch_write: assert property (@(posedge core_clk) disable iff (rst)
    (doWrite && addrHit(effAddr) && (addrSel(effAddr) == spp_pkg::SPP_REG_LATCH ||
     addrSel(effAddr) == spp_pkg::SPP_REG_LEVEL) && effMask == IMPL) |=>
    (outputLatch_reg == ($past(effData[PIN_COUNT-1:0]) & IMPL)) && bValid_reg)
    else $error("latch write lost");
  a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst)
    ((pinDirection_reg | outputLatch_reg | pinSync2_reg | pinOut_reg) & ~IMPL) == '0)
    else $error("unimplemented bit not zero");
  a_input_only_port: assert property (@(posedge core_clk) disable iff (rst)
    !rst |=> ((pinOut_reg & IN_ONLY & IMPL) == ($past(outputLatch_reg) & IN_ONLY)))
    else $error("input-only pin not port owned");
  a_write_answer: assert property (@(posedge core_clk) disable iff (rst)
    doWrite |=> bValid_reg)
    else $error("write not answered");

  c_periph_takes_pin: cover property (@(posedge core_clk) disable iff (rst) $rose(periphOwn[0]));
  c_level_write: cover property (@(posedge core_clk) disable iff (rst)
    doWrite && effAddr == `SPP_OFF_LEVEL);
  c_data_before_addr: cover property (@(posedge core_clk) disable iff (rst)
    wrState_reg == spp_pkg::SPP_WR_DATA ##1 wrState_reg == spp_pkg::SPP_WR_RESP);
  c_read_level: cover property (@(posedge core_clk) disable iff (rst)
    s_axi_arvalid && arReady_reg && s_axi_araddr == `SPP_OFF_LEVEL);

endmodule

// file: spp_map.svh
// register offsets, reset values and bus codes for the shared pin parallel port
`ifndef SPP_MAP_SVH
`define SPP_MAP_SVH
`define SPP_OFF_DIRECTION 8'h00
`define SPP_OFF_LATCH 8'h04
`define SPP_OFF_LEVEL 8'h08
`define SPP_OFF_OWNER 8'h0C
`define SPP_DIR_RESET 32'hFFFFFFFF
`define SPP_LATCH_RESET 32'h00000000
`define SPP_RESP_OKAY 2'h0
`define SPP_RESP_DECERR 2'h3
`define SPP_SYNC_STAGES 2
`endif

// file: spp_pkg.sv
// types shared by the shared pin parallel port
package spp_pkg;
  typedef enum logic [1:0] {
    SPP_WR_IDLE = 2'h0,
    SPP_WR_ADDR = 2'h1,
    SPP_WR_RESP = 2'h3,
    SPP_WR_DATA = 2'h2
  } spp_wr_state_t;
  typedef enum logic [1:0] {
    SPP_REG_DIR = 2'h0,
    SPP_REG_LATCH = 2'h1,
    SPP_REG_LEVEL = 2'h2,
    SPP_REG_OWNER = 2'h3
  } spp_reg_sel_t;
endpackage

// file: spp_pin_partner.sv
// board-side model of the pins that the shared pin port drives or reads
`timescale 1ns/1ps
module spp_pin_partner #(
  parameter int PIN_COUNT = 16
) (
  input wire logic [PIN_COUNT-1:0] pinOut,
  input wire logic [PIN_COUNT-1:0] pinOeN,
  input wire logic [PIN_COUNT-1:0] extLevel,
  output logic [PIN_COUNT-1:0] pinIn
);
  // a pin follows the device while its enable is low, else the board level set by the bench
  // a released pin does not keep the last driven value, so stale output is not read back
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pinIn[i] = (pinOeN[i] == 1'b0) ? pinOut[i] : extLevel[i];
    end
  end
endmodule

// file: spp_shared_pin_port_test.sv
// self-checking bench for the shared pin parallel port
`timescale 1ns/1ps
`include "spp_map.svh"
module spp_shared_pin_port_test;
  localparam logic [31:0] IMPL = 32'h00000FFF;
  localparam logic [31:0] INONLY = 32'h00000100;
  localparam logic [31:0] OWNABLE = IMPL & ~INONLY;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] axiProt = 3'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] pinIn, pinOut, pinOeN, periphIn;
  logic [15:0] periphEnable = 16'h0000;
  logic [15:0] periphDrive = 16'h0000;
  logic [15:0] periphOut = 16'h0000;
  logic [15:0] extLevel = 16'hA5A5;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #25 core_clk = ~core_clk;

  spp_shared_pin_port #(.PIN_COUNT(16), .IMPL_MASK(IMPL), .INPUT_ONLY_MASK(INONLY), .ADDR_W(8))
    spp_shared_pin_port_inst (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(axiProt), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(axiProt),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .periphEnable(periphEnable),
    .periphDrive(periphDrive), .periphOut(periphOut), .periphIn(periphIn));

  spp_pin_partner #(.PIN_COUNT(16)) spp_pin_partner_inst (.pinOut(pinOut), .pinOeN(pinOeN),
    .extLevel(extLevel), .pinIn(pinIn));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once its own ready is seen
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    bq.push_back(resp);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1 && !awDone) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !wDone) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    rq.push_back({resp, d});
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
  endtask

  // pin outputs lag the registers, so let a few edges land before looking
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // answers are matched in order against the notes the drivers left
  always @(posedge core_clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      if (bq.size() == 0) check(32'h1, 32'h0);
      else check(32'(s_axi_bresp), 32'(bq.pop_front()));
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (rq.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        logic [33:0] e;
        e = rq.pop_front();
        check(s_axi_rdata, e[31:0]);
        check(32'(s_axi_rresp), 32'(e[33:32]));
      end
    end
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    logic [31:0] v;
    logic [31:0] p;
    void'($urandom(32'h487AAB1D));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    // state straight out of reset
    settle(0);
    check(32'(pinOeN), 32'h0000FFFF);
    axi_read(`SPP_OFF_DIRECTION, IMPL, `SPP_RESP_OKAY);
    axi_read(`SPP_OFF_LATCH, 32'h00000000, `SPP_RESP_OKAY);
    axi_read(`SPP_OFF_OWNER, 32'h00000000, `SPP_RESP_OKAY);
    // all outputs: latch written through both the latch and the level address
    axi_write(`SPP_OFF_DIRECTION, 32'h00000000, `SPP_RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      v = $urandom();
      axi_write((k % 2 == 0) ? `SPP_OFF_LATCH : `SPP_OFF_LEVEL, v, `SPP_RESP_OKAY);
      axi_read(`SPP_OFF_LATCH, v & IMPL, `SPP_RESP_OKAY);
      settle(3);
      check(32'(pinOut) & IMPL, v & IMPL);
      check(32'(pinOeN) & IMPL, 32'h00000000);
      check(32'(periphIn) & IMPL, 32'h00000000);
      axi_read(`SPP_OFF_LEVEL, v & IMPL, `SPP_RESP_OKAY);
    end
    // all inputs: board levels reach the peripherals through two sync stages
    axi_write(`SPP_OFF_DIRECTION, 32'hFFFFFFFF, `SPP_RESP_OKAY);
    settle(4);
    check(32'(pinOeN) & IMPL, IMPL);
    check(32'(periphIn) & IMPL, 32'h0000A5A5 & IMPL);
    @(posedge core_clk);
    extLevel <= 16'h5A5A;
    settle(2);
    check(32'(periphIn) & IMPL, 32'h0000A5A5 & IMPL);
    settle(1);
    check(32'(periphIn) & IMPL, 32'h00005A5A & IMPL);
    axi_read(`SPP_OFF_LEVEL, 32'h00005A5A & IMPL, `SPP_RESP_OKAY);
    // peripherals drive every pin; the input-only one stays with the port
    axi_write(`SPP_OFF_DIRECTION, 32'h00000000, `SPP_RESP_OKAY);
    v = $urandom();
    p = $urandom();
    axi_write(`SPP_OFF_LATCH, v, `SPP_RESP_OKAY);
    @(posedge core_clk);
    periphEnable <= 16'hFFFF;
    periphDrive <= 16'hFFFF;
    periphOut <= p[15:0];
    settle(4);
    check(32'(pinOut) & IMPL, ((p & OWNABLE) | (v & ~OWNABLE)) & IMPL);
    check(32'(pinOeN) & IMPL, 32'h00000000);
    check(32'(periphIn) & IMPL, p & OWNABLE);
    axi_read(`SPP_OFF_OWNER, OWNABLE, `SPP_RESP_OKAY);
    axi_read(`SPP_OFF_LEVEL, ((p & OWNABLE) | (v & ~OWNABLE)) & IMPL, `SPP_RESP_OKAY);
    // enabled but idle peripherals leave the pins to direction and latch
    axi_write(`SPP_OFF_DIRECTION, 32'h000000F0, `SPP_RESP_OKAY);
    @(posedge core_clk);
    periphDrive <= 16'h0000;
    settle(2);
    check(32'(pinOeN) & IMPL, 32'h000000F0);
    check(32'(pinOut) & IMPL, v & IMPL);
    axi_read(`SPP_OFF_OWNER, 32'h00000000, `SPP_RESP_OKAY);
    // unmapped and misaligned places, and the read-only owner word
    axi_write(8'h10, $urandom(), `SPP_RESP_DECERR);
    axi_read(8'h10, 32'h00000000, `SPP_RESP_DECERR);
    axi_read(8'h06, 32'h00000000, `SPP_RESP_DECERR);
    axi_write(`SPP_OFF_OWNER, 32'hFFFFFFFF, `SPP_RESP_OKAY);
    axi_read(`SPP_OFF_OWNER, 32'h00000000, `SPP_RESP_OKAY);
    axi_read(`SPP_OFF_LATCH, v & IMPL, `SPP_RESP_OKAY);
    // a second reset in mid-run puts every pin back to input
    @(posedge core_clk);
    rst <= 1'b1;
    settle(0);
    check(32'(pinOeN), 32'h0000FFFF);
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    axi_read(`SPP_OFF_DIRECTION, IMPL, `SPP_RESP_OKAY);
    axi_read(`SPP_OFF_LATCH, 32'h00000000, `SPP_RESP_OKAY);
    settle(2);
    print_verdict();
  end
endmodule
